// ===== eamd_decode.sv
// Effective-address generation and transfer decode with Wishbone control registers
`include "eamd_params.svh"
`default_nettype none
// Functional notes
// RQ1 - Post-increment: base is address, then add size
// RQ2 - Pre-decrement: subtract size first, use result
// RQ3 - Four-bit displacement zero-extended, size-scaled, plus base
// RQ4 - Indexed: base plus register zero
// RQ5 - Global base plus scaled eight-bit displacement
// RQ6 - Global base plus register zero
// RQ7 - PC-relative data: PC+4 plus scaled displacement
// RQ8 - Short branch: PC+4 plus signed disp*2
// RQ9 - Long branch: PC+4 plus signed 12-bit*2
// RQ10 - Register branch: PC+4 plus register
// RQ11 - Logic and test immediates zero-extended
// RQ12 - Move, add, compare immediates sign-extended
// RQ13 - Trap immediate zero-extended times four
// RQ14 - Translation enabled: addresses go through translation
// RQ15 - Multi-space mode: present address space id
// RQ16 - Four-bit fields select registers 0 to 15
// RQ17 - Three-bit pairs 2k, banks k; vectors 0,4,8,12
// RQ18 - Privileged instructions only in privileged mode
// RQ19 - Loaded bytes and words sign-extended
// RQ20 - Conditional store: flag to test, store, clear
// RQ21 - Linked load sets flag; exceptions clear it
// RQ22 - Unaligned longword load, optional post-increment by four
// RQ23 - Address compute: aligned PC+4+disp*4 into R0
// RQ24 - Misaligned word or longword raises address error
// RQ25 - Undefined codes flagged illegal, no updates; the code flags only undefined codes with op 8
module eamd_decode (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_valid,
    input wire logic [15:0] i_instr,
    input wire logic [31:0] i_pc,
    input wire logic [31:0] i_rn_val,
    input wire logic [31:0] i_rm_val,
    input wire logic [31:0] i_r0_val,
    input wire logic i_exception,
    input wire logic i_load_valid,
    input wire eamd_pkg::eamd_size_t i_load_size,
    input wire logic [31:0] i_load_data,
    output logic o_load_valid,
    output logic [31:0] o_load_value,
    output eamd_pkg::eamd_mem_req_t o_mem,
    output eamd_pkg::eamd_dec_t o_dec,
    output logic o_link_store_flag
);
    import eamd_pkg::*;

    logic [1:0] xlat_ctl;
    logic [7:0] page_hi;
    logic [31:0] gbase;
    logic priv_mode;
    logic lsf;
    eamd_dec_t next_dec;
    eamd_mem_req_t next_mem;
    logic [31:0] load_ext;
    // Field decode lands in its own nets so next_dec has one driver
    logic [3:0] fld_gpr_n, fld_gpr_m, fld_pair_n, fld_pair_m, fld_vec_n, fld_vec_m;
    logic [2:0] fld_bank_n;

    // Wishbone slave; one wait state, unmapped reads return zero
    wire logic wb_hit = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    wire logic wb_wr = wb_hit & i_wb_we;
    wire logic [31:0] wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    wire logic [31:0] wdat = i_wb_dat & wmask;
    wire logic sel_xlat = i_wb_adr == `EAMD_OFF_XLAT;
    wire logic sel_page = i_wb_adr == `EAMD_OFF_PAGE_HI;
    wire logic sel_gbase = i_wb_adr == `EAMD_OFF_GBASE;
    wire logic sel_mode = i_wb_adr == `EAMD_OFF_MODE;
    wire logic [31:0] next_gbase = (gbase & ~wmask) | wdat;
    wire logic [31:0] rd_mux = sel_xlat ? {30'h0000_0000, xlat_ctl} :
        sel_page ? {24'h00_0000, page_hi} :
        sel_gbase ? gbase :
        sel_mode ? {30'h0000_0000, lsf, priv_mode} : 32'h0000_0000;

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_ack <= wb_hit;
            o_wb_dat <= wb_hit ? rd_mux : o_wb_dat;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            xlat_ctl <= `EAMD_XLAT_RST;
            page_hi <= `EAMD_PAGE_HI_RST;
            gbase <= `EAMD_GBASE_RST;
            priv_mode <= `EAMD_PRIV_RST;
        end else begin
            if (wb_wr && sel_xlat && i_wb_sel[0]) begin
                xlat_ctl <= i_wb_dat[1:0];
            end
            if (wb_wr && sel_page && i_wb_sel[0]) begin
                page_hi <= i_wb_dat[7:0];
            end
            if (wb_wr && sel_gbase) begin
                gbase <= next_gbase;
            end
            if (wb_wr && sel_mode && i_wb_sel[0]) begin
                priv_mode <= i_wb_dat[`EAMD_PRIV_BIT];
            end
        end
    end

    // Instruction fields
    wire logic [3:0] op = i_instr[15:12];
    wire logic [3:0] f_sub = i_instr[11:8];
    wire logic [3:0] f_m = i_instr[7:4];
    wire logic [3:0] f_lo = i_instr[3:0];
    wire logic [7:0] f_lo8 = i_instr[7:0];
    wire logic [31:0] d4 = {28'h000_0000, i_instr[3:0]};
    wire logic [31:0] d8 = {24'h00_0000, i_instr[7:0]};
    wire logic [31:0] s8 = {{24{i_instr[7]}}, i_instr[7:0]};
    wire logic [31:0] s8x2 = {{23{i_instr[7]}}, i_instr[7:0], 1'b0};
    wire logic [31:0] s12x2 = {{19{i_instr[11]}}, i_instr[11:0], 1'b0};
    wire logic [31:0] pc4 = i_pc + `EAMD_PC_AHEAD;
    wire logic [31:0] pc4l = (i_pc & `EAMD_LONG_MASK) + `EAMD_PC_AHEAD;
    wire logic lo_0_2 = f_lo <= 4'h2;
    wire logic lo_4_6 = f_lo >= 4'h4 && f_lo <= 4'h6;

    // Instruction classes
    wire logic is_mov_imm = op == 4'hE;
    wire logic is_add_imm = op == 4'h7;
    wire logic is_pcw = op == 4'h9;
    wire logic is_pcl = op == 4'hD;
    wire logic is_ld_ind = op == 4'h6 && lo_0_2;
    wire logic is_ld_post = op == 4'h6 && lo_4_6;
    wire logic is_st_ind = op == 4'h2 && lo_0_2;
    wire logic is_st_pre = op == 4'h2 && lo_4_6;
    wire logic is_st_d4 = op == 4'h8 && f_sub <= 4'h1;
    wire logic is_ld_d4 = op == 4'h8 && (f_sub == 4'h4 || f_sub == 4'h5);
    wire logic is_cmp_imm = op == 4'h8 && f_sub == 4'h8;
    wire logic is_bcond = op == 4'h8 && f_sub[0] && f_sub[3];
    wire logic is_st_dl = op == 4'h1;
    wire logic is_ld_dl = op == 4'h5;
    wire logic is_st_idx = op == 4'h0 && lo_4_6;
    wire logic is_ld_idx = op == 4'h0 && f_lo >= 4'hC && f_lo <= 4'hE;
    wire logic is_cstore = op == 4'h0 && f_lo8 == 8'h73;
    wire logic is_lload = op == 4'h0 && f_lo8 == 8'h63;
    wire logic is_rbr = op == 4'h0 && (f_lo8 == 8'h23 || f_lo8 == 8'h03);
    wire logic is_gst = op == 4'hC && f_sub <= 4'h2;
    wire logic is_trap = op == 4'hC && f_sub == 4'h3;
    wire logic is_gld = op == 4'hC && f_sub >= 4'h4 && f_sub <= 4'h6;
    wire logic is_address_compute_op = op == 4'hC && f_sub == 4'h7;
    wire logic is_zimm = op == 4'hC && f_sub >= 4'h8 && f_sub <= 4'hB;
    wire logic is_gidx = op == 4'hC && f_sub >= 4'hC;
    wire logic is_bra = op == 4'hA || op == 4'hB;
    wire logic is_ua = op == 4'h4 && f_lo8 == 8'hA9;
    wire logic is_ua_post = op == 4'h4 && f_lo8 == 8'hE9;
    // Control-register loads other than the global base are privileged
    wire logic is_priv = op == 4'h4 && (((f_lo == 4'hE || f_lo == 4'h7) && f_m != 4'h1) ||
        f_lo8 == 8'h3A || f_lo8 == 8'h36 || f_lo8 == 8'hFA || f_lo8 == 8'hF6);
    wire logic is_illegal = op == 4'h8 && !(is_st_d4 || is_ld_d4 || is_cmp_imm || is_bcond); // [RQ25]

    // Operand size and base register
    wire logic [1:0] sz_raw = (op == 4'h8 || op == 4'hC) ? (is_gidx ? 2'h0 : f_sub[1:0]) :
        is_pcw ? 2'h1 :
        ((op == 4'h2 || op == 4'h6 || op == 4'h0) && !(is_cstore || is_lload)) ? f_lo[1:0] : 2'h2;
    wire eamd_size_t sz = eamd_size_t'(sz_raw);
    wire logic [31:0] step = 32'h0000_0001 << sz_raw;
    wire logic use_m = op == 4'h6 || op == 4'h8 || op == 4'h5 || is_ld_idx;
    wire logic [31:0] base = use_m ? i_rm_val : i_rn_val;

    wire logic [31:0] ea = is_pcw ? pc4 + (d8 << 1) : // [RQ7]
        is_pcl ? pc4l + (d8 << 2) : // [RQ7]
        (is_gst || is_gld) ? gbase + (d8 << sz_raw) : // [RQ5]
        is_gidx ? gbase + i_r0_val : // [RQ6]
        (is_st_idx || is_ld_idx) ? base + i_r0_val : // [RQ4]
        (is_st_d4 || is_ld_d4 || is_st_dl || is_ld_dl) ? base + (d4 << sz_raw) : // [RQ3]
        is_st_pre ? base - step : // [RQ2]
        base; // [RQ1] [RQ22]

    wire logic is_ua_any = is_ua || is_ua_post; // [RQ22]
    wire logic mem_rd = is_pcw || is_pcl || is_ld_ind || is_ld_post || is_ld_d4 || is_ld_dl || is_ld_idx ||
        is_gld || is_gidx || is_lload || is_ua_any;
    wire logic mem_wr = is_st_ind || is_st_pre || is_st_d4 || is_st_dl || is_st_idx || is_gst ||
        (is_gidx && f_sub != 4'hC) || (is_cstore && lsf); // [RQ20]
    wire logic mem_any = mem_rd || mem_wr || is_cstore;
    wire logic priv_f = is_priv && !priv_mode; // [RQ18]
    // Unaligned loads are exempt; byte accesses never fault
    wire logic misalign = mem_any && !is_ua_any &&
        ((sz == EAMD_SZ_WORD && ea[0]) || (sz == EAMD_SZ_LONG && ea[1:0] != 2'h0)); // [RQ24]
    wire logic fault = is_illegal || priv_f || misalign;
    wire logic ok = i_valid && !fault;
    wire logic do_lload = ok && is_lload;
    wire logic do_cstore = ok && is_cstore;

    wire logic [31:0] br_target = is_bcond ? pc4 + s8x2 : // [RQ8]
        is_bra ? pc4 + s12x2 : // [RQ9]
        pc4 + i_rn_val; // [RQ10]
    wire logic [31:0] imm = is_trap ? d8 << 2 : // [RQ13]
        (is_zimm || is_gidx) ? d8 : // [RQ11]
        s8; // [RQ12]

    eamd_reg_field u_reg_field (
        .i_instr(i_instr),
        .o_gpr_n(fld_gpr_n),
        .o_gpr_m(fld_gpr_m),
        .o_pair_n(fld_pair_n),
        .o_pair_m(fld_pair_m),
        .o_bank_n(fld_bank_n),
        .o_vec_n(fld_vec_n),
        .o_vec_m(fld_vec_m)
    );

    eamd_load_ext u_load_ext (
        .i_size(i_load_size),
        .i_data(i_load_data),
        .o_value(load_ext)
    );

    always_comb begin
        next_dec.valid = i_valid;
        next_dec.illegal = i_valid && is_illegal; // [RQ25]
        next_dec.priv_fault = i_valid && priv_f; // [RQ18]
        next_dec.addr_err = i_valid && !is_illegal && !priv_f && misalign; // [RQ24]
        next_dec.branch = ok && (is_bcond || is_bra || is_rbr);
        next_dec.target = br_target;
        next_dec.imm_en = ok && (is_mov_imm || is_add_imm || is_cmp_imm || is_zimm || is_gidx || is_trap);
        next_dec.imm = imm;
        next_dec.base_wb = ok && (is_ld_post || is_st_pre || is_ua_post); // [RQ1] [RQ2] [RQ22]
        next_dec.base_val = is_st_pre ? ea : base + step;
        next_dec.r0_wb = ok && is_address_compute_op; // [RQ23]
        next_dec.r0_val = pc4l + (d8 << 2); // [RQ23]
        next_dec.test_wr = do_cstore;
        next_dec.test_flag = lsf; // [RQ20]
        next_dec.gpr_n = fld_gpr_n; // [RQ16]
        next_dec.gpr_m = fld_gpr_m; // [RQ16]
        next_dec.pair_n = fld_pair_n; // [RQ17]
        next_dec.pair_m = fld_pair_m; // [RQ17]
        next_dec.bank_n = fld_bank_n; // [RQ17]
        next_dec.vec_n = fld_vec_n; // [RQ17]
        next_dec.vec_m = fld_vec_m; // [RQ17]
        next_mem.rd = ok && mem_rd;
        next_mem.wr = ok && mem_wr;
        next_mem.size = sz;
        next_mem.addr = ea;
        next_mem.translate = xlat_ctl[`EAMD_XLAT_EN_BIT]; // [RQ14]
        next_mem.address_space_id_en = xlat_ctl[`EAMD_XLAT_EN_BIT] && !xlat_ctl[`EAMD_SSPACE_BIT]; // [RQ15]
        next_mem.address_space_id = page_hi;
    end

    // Set wins over an exception in the same cycle
    wire logic next_lsf = do_lload ? 1'b1 : (do_cstore || i_exception) ? 1'b0 : lsf; // [RQ20] [RQ21]
    assign o_link_store_flag = lsf;

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_dec <= '0;
            o_mem <= '0;
            lsf <= 1'b0;
            o_load_valid <= 1'b0;
            o_load_value <= 32'h0000_0000;
        end else begin
            o_dec <= next_dec;
            o_mem <= next_mem;
            lsf <= next_lsf;
            o_load_valid <= i_load_valid;
            o_load_value <= load_ext; // [RQ19]
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    a_post_inc_step: assert property (ok && is_ld_post |=> o_dec.base_wb && // [RQ1]
        o_dec.base_val - o_mem.addr == (32'h0000_0001 << o_mem.size)) else $error("post-increment step wrong");
    a_pre_dec_addr: assert property (ok && is_st_pre |=> o_mem.wr && // [RQ2]
        o_mem.addr == o_dec.base_val && o_mem.addr == $past(i_rn_val) - $past(step)) else $error("pre-decrement wrong");
    a_disp_scale: assert property (ok && is_ld_d4 |=> // [RQ3]
        o_mem.addr == $past(i_rm_val) + ($past(d4) << o_mem.size)) else $error("displacement scaling wrong");
    a_gbase_index: assert property (ok && is_gidx |=> // [RQ6]
        o_mem.addr == $past(gbase) + $past(i_r0_val) && o_mem.size == EAMD_SZ_BYTE) else $error("global index wrong");
    a_long_branch: assert property (ok && is_bra |=> o_dec.branch && // [RQ9]
        o_dec.target == $past(i_pc) + `EAMD_PC_AHEAD + $past(s12x2)) else $error("long branch target wrong");
    a_trap_scale: assert property (ok && is_trap |=> o_dec.imm_en && // [RQ13]
        o_dec.imm[1:0] == 2'h0 && o_dec.imm[31:10] == 22'h00_0000) else $error("trap immediate wrong");
    a_priv_block: assert property (i_valid && is_priv && !priv_mode |=> // [RQ18]
        o_dec.priv_fault && !o_mem.rd && !o_mem.wr && !o_dec.base_wb) else $error("privileged op not blocked");
    a_cstore_flag: assert property (do_cstore |=> o_dec.test_flag == $past(lsf) && // [RQ20]
        o_mem.wr == $past(lsf) && !lsf) else $error("conditional store wrong");
    a_lload_set: assert property (do_lload |=> lsf && o_mem.rd && o_mem.size == EAMD_SZ_LONG) // [RQ21]
        else $error("linked load did not set flag");
    a_align_err: assert property (i_valid && !is_illegal && !priv_f && mem_any && !is_ua_any && // [RQ24]
        sz == EAMD_SZ_WORD && ea[0] |=> o_dec.addr_err && !o_mem.rd && !o_mem.wr) else $error("odd word not caught");
    a_illegal_quiet: assert property (i_valid && is_illegal |=> o_dec.illegal && // [RQ25]
        !o_mem.rd && !o_mem.wr && !o_dec.base_wb && !o_dec.r0_wb) else $error("illegal op caused update");
    a_xlat_space: assert property (o_mem.address_space_id_en |-> o_mem.translate && // [RQ15]
        o_mem.address_space_id == $past(page_hi)) else $error("space id without translation");

    c_post_inc: cover property (ok && is_ld_post);
    c_cstore_ok: cover property (do_cstore && lsf);
    c_addr_err: cover property (o_dec.addr_err);
    c_wb_write: cover property (wb_wr && sel_gbase ##2 ok && is_gld);
endmodule // eamd_decode
`default_nettype wire

// ===== eamd_load_ext.sv
// Sign extension of loaded bytes and words
`default_nettype none
module eamd_load_ext (
    input wire eamd_pkg::eamd_size_t i_size,
    input wire logic [31:0] i_data,
    output logic [31:0] o_value
);
    import eamd_pkg::*;
    wire logic [31:0] byte_ext = {{24{i_data[7]}}, i_data[7:0]};
    wire logic [31:0] word_ext = {{16{i_data[15]}}, i_data[15:0]};
    assign o_value = (i_size == EAMD_SZ_BYTE) ? byte_ext : (i_size == EAMD_SZ_WORD) ? word_ext : i_data; // [RQ19]
endmodule // eamd_load_ext
`default_nettype wire

// ===== eamd_lsu_model.sv
// Load/store unit model that answers the decoder's read requests
`default_nettype none
module eamd_lsu_model #(
    parameter int WAIT_CYC = 0
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire eamd_pkg::eamd_mem_req_t i_mem,
    output logic o_load_valid,
    output eamd_pkg::eamd_size_t o_load_size,
    output logic [31:0] o_load_data
);
    import eamd_pkg::*;
    // Junk in the upper bits, so narrow loads must ignore them
    localparam logic [31:0] RAW = 32'h1234_8680;
    logic pend = 1'b0;
    int cnt = 0;
    eamd_size_t psz = EAMD_SZ_BYTE;
    initial begin
        o_load_valid = 1'b0;
        o_load_size = EAMD_SZ_BYTE;
        o_load_data = 32'h0000_0000;
    end
    always @(posedge i_ref_clk) begin
        o_load_valid <= 1'b0;
        // Data is not held after the answer: toggle so stale bits never match
        o_load_data <= ~o_load_data;
        if (i_reset) begin
            pend <= 1'b0;
        end else if (pend && cnt != 0) begin
            cnt <= cnt - 1;
        end else if (pend) begin
            pend <= 1'b0;
            o_load_valid <= 1'b1;
            o_load_size <= psz;
            o_load_data <= RAW;
        end else if (i_mem.rd) begin
            pend <= 1'b1;
            cnt <= WAIT_CYC;
            psz <= i_mem.size;
        end
    end
endmodule // eamd_lsu_model
`default_nettype wire

// ===== eamd_params.svh
// Offsets, field positions, reset values and constants for the EA and move decoder
`ifndef EAMD_PARAMS_SVH
`define EAMD_PARAMS_SVH
`define EAMD_OFF_XLAT 8'h00
`define EAMD_OFF_PAGE_HI 8'h04
`define EAMD_OFF_GBASE 8'h08
`define EAMD_OFF_MODE 8'h0C
`define EAMD_XLAT_EN_BIT 0
`define EAMD_SSPACE_BIT 1
`define EAMD_PRIV_BIT 0
`define EAMD_LSF_BIT 1
`define EAMD_XLAT_RST 2'h0
`define EAMD_PAGE_HI_RST 8'h00
`define EAMD_GBASE_RST 32'h0000_0000
`define EAMD_PRIV_RST 1'b1
`define EAMD_PC_AHEAD 32'h0000_0004
`define EAMD_LONG_MASK 32'hFFFF_FFFC
`endif

// ===== eamd_pkg.sv
// Types shared by the EA and move decoder
`default_nettype none
package eamd_pkg;
    typedef enum logic [1:0] {
        EAMD_SZ_BYTE = 2'h0,
        EAMD_SZ_WORD = 2'h1,
        EAMD_SZ_LONG = 2'h2,
        EAMD_SZ_QUAD = 2'h3
    } eamd_size_t;
    typedef struct packed {
        logic rd;
        logic wr;
        eamd_size_t size;
        logic [31:0] addr;
        logic translate;
        logic address_space_id_en;
        logic [7:0] address_space_id;
    } eamd_mem_req_t;
    typedef struct packed {
        logic valid;
        logic illegal;
        logic priv_fault;
        logic addr_err;
        logic branch;
        logic [31:0] target;
        logic imm_en;
        logic [31:0] imm;
        logic base_wb;
        logic [31:0] base_val;
        logic r0_wb;
        logic [31:0] r0_val;
        logic test_wr;
        logic test_flag;
        logic [3:0] gpr_n;
        logic [3:0] gpr_m;
        logic [3:0] pair_n;
        logic [3:0] pair_m;
        logic [2:0] bank_n;
        logic [3:0] vec_n;
        logic [3:0] vec_m;
    } eamd_dec_t;
endpackage
`default_nettype wire

// ===== eamd_reg_field.sv
// Register-number field decode
`default_nettype none
module eamd_reg_field (
    input wire logic [15:0] i_instr,
    output logic [3:0] o_gpr_n,
    output logic [3:0] o_gpr_m,
    output logic [3:0] o_pair_n,
    output logic [3:0] o_pair_m,
    output logic [2:0] o_bank_n,
    output logic [3:0] o_vec_n,
    output logic [3:0] o_vec_m
);
    assign o_gpr_n = i_instr[11:8]; // [RQ16]
    assign o_gpr_m = i_instr[7:4]; // [RQ16]
    assign o_pair_n = {i_instr[11:9], 1'b0}; // [RQ17]
    assign o_pair_m = {i_instr[7:5], 1'b0}; // [RQ17]
    assign o_bank_n = i_instr[6:4]; // [RQ17]
    // Vector numbers step by four
    assign o_vec_n = {i_instr[11:10], 2'h0}; // [RQ17]
    assign o_vec_m = {i_instr[9:8], 2'h0}; // [RQ17]
endmodule // eamd_reg_field
`default_nettype wire

// ===== test_ea_calc_and_move_decode.sv
// Self-checking bench for the EA and move decoder
`default_nettype none
module test_ea_calc_and_move_decode;
    timeunit 1ns;
    timeprecision 1ps;
    import eamd_pkg::*;
    logic i_ref_clk = 1'b0, i_reset = 1'b1, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
    logic i_valid = 1'b0, i_exception = 1'b0, o_wb_ack, o_load_valid, o_link_store_flag, i_load_valid;
    logic [7:0] i_wb_adr = 8'h00;
    logic [3:0] i_wb_sel = 4'h0;
    logic [15:0] i_instr = 16'h0000;
    logic [31:0] i_wb_dat = 32'h0000_0000, i_pc = 32'h0000_0000, i_rn_val = 32'h0000_0000;
    logic [31:0] i_rm_val = 32'h0000_0000, i_r0_val = 32'h0000_0000;
    logic [31:0] o_wb_dat, o_load_value, i_load_data, q;
    eamd_size_t i_load_size;
    eamd_mem_req_t o_mem, m;
    eamd_dec_t o_dec, d;
    int errors = 0, total_checks = 0;
    always #5 i_ref_clk = ~i_ref_clk;
    eamd_decode eamd_decode_i (.i_ref_clk, .i_reset, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
        .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_valid, .i_instr, .i_pc, .i_rn_val, .i_rm_val, .i_r0_val,
        .i_exception, .i_load_valid, .i_load_size, .i_load_data, .o_load_valid, .o_load_value, .o_mem,
        .o_dec, .o_link_store_flag);
    // Slow answers, so the load path is not tuned to a fixed gap
    eamd_lsu_model #(.WAIT_CYC(2)) eamd_lsu_model_i (.i_ref_clk, .i_reset, .i_mem(o_mem),
        .o_load_valid(i_load_valid), .o_load_size(i_load_size), .o_load_data(i_load_data));
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic tmo();
        errors++;
        $display("wrong value at %0t: wait ran out", $time);
        give_verdict();
    endtask
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dat);
        int n;
        n = 0;
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= w;
        i_wb_adr <= a;
        i_wb_sel <= 4'hF;
        i_wb_dat <= dat;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 20);
        if (o_wb_ack !== 1'b1) tmo();
        q = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        @(posedge i_ref_clk);
    endtask
    // Result stands one cycle; read it at the edge that ends that cycle
    task automatic op(input logic [15:0] ins, input logic [31:0] pc, input logic [31:0] rn, input logic [31:0] rm);
        i_valid <= 1'b1;
        i_instr <= ins;
        i_pc <= pc;
        i_rn_val <= rn;
        i_rm_val <= rm;
        @(posedge i_ref_clk);
        i_valid <= 1'b0;
        @(posedge i_ref_clk);
        d = o_dec;
        m = o_mem;
    endtask
    task automatic t_regs();
        wb(1'b0, 8'h00, 32'h0000_0000);
        chk(q, 64'h0);
        wb(1'b0, 8'h0C, 32'h0000_0000);
        chk(q, 64'h1);
        wb(1'b1, 8'h10, 32'hFFFF_FFFF);
        wb(1'b0, 8'h10, 32'h0000_0000);
        chk(q, 64'h0);
        wb(1'b1, 8'h08, 32'h0000_1000);
        wb(1'b0, 8'h08, 32'h0000_0000);
        chk(q, 64'h1000);
    endtask
    task automatic t_postpre();
        for (int i = 0; i < 3; i++) begin
            op(16'h6144 + 16'(i), 32'h0, 32'h0, 32'h0000_0100);
            chk({m.rd, m.addr, d.base_wb, d.base_val}, {1'b1, 32'h0000_0100, 1'b1, 32'h0000_0100 + (32'h1 << i)});
            op(16'h2124 + 16'(i), 32'h0, 32'h0000_0200, 32'h0);
            chk({m.wr, m.addr, d.base_val}, {1'b1, 32'h0000_0200 - (32'h1 << i), 32'h0000_0200 - (32'h1 << i)});
        end
    endtask
    task automatic t_disp();
        op(16'h512F, 32'h0, 32'h0, 32'h0000_0100);
        chk({m.size, m.addr}, {EAMD_SZ_LONG, 32'h0000_013C});
        op(16'h851F, 32'h0, 32'h0, 32'h0000_0100);
        chk({m.size, m.addr}, {EAMD_SZ_WORD, 32'h0000_011E});
        op(16'h841F, 32'h0, 32'h0, 32'h0000_0100);
        chk(m.addr, 64'h010F);
        i_r0_val <= 32'h0000_0030;
        op(16'h012E, 32'h0, 32'h0, 32'h0000_0100);
        chk(m.addr, 64'h0130);
    endtask
    task automatic t_gbase();
        op(16'hC6FF, 32'h0, 32'h0, 32'h0);
        chk(m.addr, 64'h13FC);
        op(16'hC4FF, 32'h0, 32'h0, 32'h0);
        chk(m.addr, 64'h10FF);
        op(16'hCC80, 32'h0, 32'h0, 32'h0);
        chk({m.rd, m.wr, m.addr, d.imm}, {2'b10, 32'h0000_1030, 32'h0000_0080});
        for (int i = 0; i < 4; i++) begin
            op(16'hC880 + 16'(i << 8), 32'h0, 32'h0, 32'h0);
            chk({d.imm_en, d.imm}, {1'b1, 32'h0000_0080});
        end
    endtask
    task automatic t_pcrel();
        op(16'hD1FF, 32'h0000_1002, 32'h0, 32'h0);
        chk(m.addr, 64'h1400);
        op(16'h91FF, 32'h0000_1002, 32'h0, 32'h0);
        chk(m.addr, 64'h1204);
        op(16'hC7FF, 32'h0000_1002, 32'h0, 32'h0);
        chk({m.rd, d.r0_wb, d.r0_val}, {2'b01, 32'h0000_1400});
        op(16'hA800, 32'h0000_1000, 32'h0, 32'h0);
        chk({d.branch, d.target}, {1'b1, 32'h0000_0004});
        op(16'h89FF, 32'h0000_1000, 32'h0, 32'h0);
        chk({d.branch, d.target}, {1'b1, 32'h0000_1002});
        op(16'h0123, 32'h0000_1000, 32'h0000_0010, 32'h0);
        chk({d.branch, d.target}, {1'b1, 32'h0000_1014});
    endtask
    task automatic t_imm_fields();
        logic [15:0] ops [3] = '{16'hE180, 16'h7180, 16'h8880};
        foreach (ops[i]) begin
            op(ops[i], 32'h0, 32'h0, 32'h0);
            chk({d.imm_en, d.imm}, {1'b1, 32'hFFFF_FF80});
        end
        op(16'hC3FF, 32'h0, 32'h0, 32'h0);
        chk(d.imm, 64'h03FC);
        op(16'h6AB3, 32'h0, 32'h0, 32'h0);
        chk({d.gpr_n, d.gpr_m}, 64'hAB);
        chk({d.pair_n, d.bank_n, d.vec_n}, {4'hA, 3'h3, 4'h8});
    endtask
    task automatic t_xlat_priv();
        wb(1'b1, 8'h04, 32'h0000_005A);
        wb(1'b1, 8'h00, 32'h0000_0001);
        op(16'h6142, 32'h0, 32'h0, 32'h0000_0100);
        chk({m.translate, m.address_space_id_en, m.address_space_id}, {2'b11, 8'h5A});
        wb(1'b1, 8'h00, 32'h0000_0003);
        op(16'h6142, 32'h0, 32'h0, 32'h0000_0100);
        chk({m.translate, m.address_space_id_en}, 64'h2);
        wb(1'b1, 8'h00, 32'h0000_0000);
        wb(1'b1, 8'h0C, 32'h0000_0000);
        op(16'h410E, 32'h0, 32'h0, 32'h0);
        chk({d.priv_fault, m.rd, d.base_wb}, 64'h4);
        op(16'h4107, 32'h0, 32'h0, 32'h0000_0100);
        chk({d.priv_fault, m.rd, d.base_wb}, 64'h4);
        wb(1'b1, 8'h0C, 32'h0000_0001);
        op(16'h410E, 32'h0, 32'h0, 32'h0);
        chk(d.priv_fault, 64'h0);
    endtask
    task automatic t_load();
        logic [31:0] exp [3] = '{32'hFFFF_FF80, 32'hFFFF_8680, 32'h1234_8680};
        int n;
        foreach (exp[i]) begin
            n = 0;
            op(16'h6140 + 16'(i), 32'h0, 32'h0, 32'h0000_0100);
            while (o_load_valid !== 1'b1 && n < 20) begin
                @(posedge i_ref_clk);
                n++;
            end
            if (o_load_valid !== 1'b1) tmo();
            chk(o_load_value, exp[i]);
        end
    endtask
    task automatic t_link();
        op(16'h0163, 32'h0, 32'h0, 32'h0000_0100);
        chk({m.rd, m.size, o_link_store_flag}, {1'b1, EAMD_SZ_LONG, 1'b1});
        op(16'h0173, 32'h0, 32'h0000_0200, 32'h0);
        chk({m.wr, d.test_wr, d.test_flag, o_link_store_flag}, 64'hE);
        op(16'h0173, 32'h0, 32'h0000_0200, 32'h0);
        chk({m.wr, d.test_wr, d.test_flag}, 64'h2);
        op(16'h0163, 32'h0, 32'h0, 32'h0000_0100);
        i_exception <= 1'b1;
        @(posedge i_ref_clk);
        i_exception <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        chk(o_link_store_flag, 64'h0);
    endtask
    task automatic t_err();
        op(16'h6141, 32'h0, 32'h0, 32'h0000_0101);
        chk({d.addr_err, m.rd}, 64'h2);
        op(16'h6142, 32'h0, 32'h0, 32'h0000_0102);
        chk({d.addr_err, m.rd}, 64'h2);
        op(16'h6140, 32'h0, 32'h0, 32'h0000_0101);
        chk({d.addr_err, m.rd}, 64'h1);
        op(16'h40E9, 32'h0, 32'h0000_0101, 32'h0);
        chk({d.addr_err, m.rd, m.addr, d.base_val}, {2'b01, 32'h0000_0101, 32'h0000_0105});
        op(16'h8200, 32'h0, 32'h0, 32'h0);
        chk({d.illegal, m.rd, m.wr, d.branch, d.imm_en, d.base_wb}, 64'h20);
    endtask
    initial begin
        repeat (3) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        t_regs();
        t_postpre();
        t_disp();
        t_gbase();
        t_pcrel();
        t_imm_fields();
        t_xlat_priv();
        t_load();
        t_link();
        t_err();
        give_verdict();
    end
endmodule // test_ea_calc_and_move_decode
`default_nettype wire
